//--- rtl/srds_map.svh
// register map, field positions, reset values and timing figures of the rate select block
`ifndef SRDS_MAP_SVH
`define SRDS_MAP_SVH

// register indices; byte address is four times the index
`define SRDS_IDX_RATE_CFG      8'h17
`define SRDS_IDX_CTRL          8'h20
`define SRDS_IDX_WAKE_IDLE     8'h21
`define SRDS_IDX_SLEEP_IDLE    8'h22
`define SRDS_IDX_STATUS        8'h23

// rate config fields
`define SRDS_WAKE_CODE_MSB     7
`define SRDS_WAKE_CODE_LSB     4
`define SRDS_SLEEP_CODE_MSB    3
`define SRDS_SLEEP_CODE_LSB    0

// reset values of the rate config, chosen by the boot mode pin
`define SRDS_RATE_RST_GND      8'h00
`define SRDS_RATE_RST_VDD      8'hC0

// control register fields
`define SRDS_CTRL_RUN_BIT      0
`define SRDS_CTRL_PIN2_BIT     1
`define SRDS_CTRL_RDY_EN_BIT   2
`define SRDS_CTRL_WAKE_POWER_SELECT_LSB  4
`define SRDS_CTRL_SLEEP_POWER_SELECT_LSB 6
`define SRDS_CTRL_RST          8'h00

// status register fields
`define SRDS_STAT_STANDBY_BIT  0
`define SRDS_STAT_ACQ_BIT      1
`define SRDS_STAT_GAP_BIT      2
`define SRDS_STAT_SLEEP_BIT    3
`define SRDS_STAT_SHIFT_LSB    4
`define SRDS_STAT_AVG_LSB      16

// idle time width and reset
`define SRDS_IDLE_RST          12'h000

// largest decimation step; codes above it saturate
`define SRDS_MAX_SHIFT         4'hC

// timing figures in ns and the clock period in ns
`define SRDS_CLK_NS            10
`define SRDS_UNIT_NS           312500
`define SRDS_FIRST_BASE_NS     528500
`define SRDS_FIRST_STEP_NUM    9984
`define SRDS_FIRST_STEP_DEN    10000
`define SRDS_GAP_NS            500000
`define SRDS_PULSE_NS          5000000

`endif

//--- rtl/srds_pkg.sv
// types shared by the rate select block
package srds_pkg;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    SRDS_ST_STANDBY = 3'b001,
    SRDS_ST_ACQ     = 3'b010,
    SRDS_ST_GAP     = 3'b100
  } srds_state_t;

  // power setting selected by a two-bit power select field
  typedef enum logic [1:0] {
    SRDS_PM_LOW_CURRENT = 2'b00,
    SRDS_PM_HIGH_PREC   = 2'b01,
    SRDS_PM_TUNABLE     = 2'b10,
    SRDS_PM_TUNABLE_ALT = 2'b11
  } srds_power_t;

endpackage

//--- rtl/srds_rate_decode.sv
// decodes one rate code field with its power select and idle time into timing figures
`timescale 1ns/1ns
`include "srds_map.svh"
module srds_rate_decode
  import srds_pkg::*;
(
  // field inputs
  input  wire logic [3:0]  code_i,        // rate or average-count code
  input  wire logic [1:0]  power_i,       // power select of this state
  input  wire logic [11:0] idle_i,        // idle time of this state
  // decoded outputs
  output logic      [3:0]  shift_o,       // log2 of period in base units before idle
  output logic      [12:0] avg_count_o,   // samples averaged per output
  output logic      [24:0] units_o,       // output period in 312.5 us units
  output logic             fast_start_o   // first sample uses the start-up delay
);

  logic tunable;   // tunable setting takes the code as an average count

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // codes past twelve all saturate at the slowest step
  always_comb
  begin
    tunable      = power_i[1];                                               // RULE17
    shift_o      = (code_i > `SRDS_MAX_SHIFT) ? `SRDS_MAX_SHIFT : code_i;    // RULE3 RULE4 RULE18
    if (power_i == SRDS_PM_LOW_CURRENT)
      avg_count_o = 13'h0001;                                                // RULE3
    else
      avg_count_o = 13'(13'h0001 << shift_o);                                // RULE4 RULE18 RULE7
    if (tunable)
      units_o = 25'((25'(idle_i) + 25'h000_0001) << shift_o);               // RULE5 RULE6 RULE8
    else
      units_o = 25'(25'h000_0001 << shift_o);                               // RULE3 RULE4
    // fastest rate, or zero idle time when tunable
    if (tunable)
      fast_start_o = (idle_i == 12'h000);                                    // RULE9
    else
      fast_start_o = (code_i == 4'h0);                                       // RULE9
  end

endmodule

//--- rtl/srds_pulse_timer.sv
// retriggerable pulse of fixed length, used for the motion-detect interrupt pulse
`timescale 1ns/1ns
module srds_pulse_timer #(
  parameter int LEN = 500000   // pulse length in clock cycles
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // trigger and pulse
  input  wire logic trigger_i,  // one-cycle start, restarts a running pulse
  output logic      active_o    // high for LEN cycles after each trigger
);

  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt_r;  // cycles left in the pulse

  if (LEN < 1)
  begin : g_chk
    $error("srds_pulse_timer: LEN must be at least 1");
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_r <= '0;
    else if (trigger_i)
      cnt_r <= CW'(LEN);
    else if (cnt_r != '0)
      cnt_r <= cnt_r - CW'(1);
  end

  assign active_o = (cnt_r != '0);

endmodule

//--- rtl/srds_rate_select.sv
// rate and decimation select with output-rate sequencer and register slave
//
// Notes on behaviour
// RULE1: wake code high nibble, sleep code low
// RULE2: reset value follows boot mode pin
// RULE3: low current: decimation 1, rate halves per code
// RULE4: high precision: same rate, decimation doubles
// RULE5: tunable: codes are average counts with idle
// RULE6: tunable period is (idle+1)*312.5us*count
// RULE7: wake select 10b reads high nibble as count
// RULE8: sleep rate uses low nibble, sleep idle
// RULE9: fast settings use 528.5us start-up delay
// RULE10: later samples at rate; else within period
// RULE11: idle time follows current wake/sleep state
// RULE12: 500us gap on each wake/sleep change
// RULE13: host changes rate only in standby
// RULE14: host keeps low current with boot pin high
// RULE15: boot pin high: pulse interrupt line low
// RULE16: host keeps rate at most 100Hz then
// RULE17: select 00 low, 01 precise, 1x tunable
// RULE18: tunable count doubles to 4096, 0.3125ms each
// RULE19: wake field in wake, sleep field asleep
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ns
`include "srds_map.svh"
module srds_rate_select
  import srds_pkg::*;
#(
  // cycle counts; all above 4096 so a bench may shorten them
  parameter int UNIT_CYC   = (`SRDS_UNIT_NS + `SRDS_CLK_NS - 1) / `SRDS_CLK_NS,
  parameter int FIRST_BASE = (`SRDS_FIRST_BASE_NS + `SRDS_CLK_NS - 1) / `SRDS_CLK_NS,
  // scaled down first so the product stays inside 32 bits without losing the fraction
  parameter int FIRST_STEP = (`SRDS_UNIT_NS / 100 * `SRDS_FIRST_STEP_NUM / (`SRDS_FIRST_STEP_DEN / 100)
                              + `SRDS_CLK_NS - 1) / `SRDS_CLK_NS,
  parameter int GAP_CYC    = (`SRDS_GAP_NS + `SRDS_CLK_NS - 1) / `SRDS_CLK_NS,
  parameter int PULSE_CYC  = (`SRDS_PULSE_NS + `SRDS_CLK_NS - 1) / `SRDS_CLK_NS
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // pins and neighbouring blocks
  input  wire logic        boot_mode_pin_i,      // high when strapped to supply
  input  wire logic        sleep_state_i,        // high while the sensor is in its sleep state
  // sample timing
  output logic             sample_ready_o,       // one-cycle pulse per output sample
  output logic      [12:0] avg_count_o,          // samples averaged in the current state
  output logic             first_irq_line_n_o    // active-low interrupt line
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (UNIT_CYC < 1 || FIRST_BASE < 1 || FIRST_STEP < 1 || GAP_CYC < 1 || PULSE_CYC < 1)
  begin : g_chk
    $error("srds_rate_select: every cycle count must be at least 1");
  end
  if (UNIT_CYC >= 32768 || FIRST_BASE >= 65536 || FIRST_STEP >= 32768 || GAP_CYC >= 65536)
  begin : g_chk_w
    $error("srds_rate_select: cycle count too wide for the timer");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // registers
  logic [7:0]  rate_cfg_r;         // wake code [7:4], sleep code [3:0]
  logic        run_en_r;           // sequencer runs when set
  logic        pin2_func_r;        // second pin function, blocks rate changes
  logic        rdy_irq_en_r;       // sample ready interrupt enable
  logic [1:0]  wake_power_select_r;          // wake power select
  logic [1:0]  sleep_power_select_r;         // sleep power select
  logic [11:0] wake_idle_r;        // wake idle time
  logic [11:0] sleep_idle_r;       // sleep idle time
  logic        boot_done_r;        // strap loaded after reset release
  // bus
  logic        ack_r;              // answer cycle of a taken request
  logic [31:0] rdata_r;            // registered read data
  logic        req;                // request pending and not yet answered
  logic        wr_take;            // write takes effect this edge
  logic [7:0]  idx;                // word index of the request
  logic [31:0] rd_mux;             // read data before the register
  // sequencer
  srds_state_t state_r;            // sequencer state
  srds_state_t state_nxt;
  logic [39:0] cnt_r;              // cycles to the next event
  logic [39:0] cnt_nxt;
  logic        sleep_applied_r;    // state whose field is in use
  logic        sample_r;           // sample pulse register
  logic        sample_nxt;
  logic [12:0] avg_r;              // applied average count
  // decoded figures of each field
  logic [3:0]  wake_shift;
  logic [3:0]  sleep_shift;
  logic [12:0] wake_avg;
  logic [12:0] sleep_avg;
  logic [24:0] wake_units;
  logic [24:0] sleep_units;
  logic        wake_fast;
  logic        sleep_fast;
  // figures of the state that follows
  logic        tgt_sleep;          // state to apply next
  logic [3:0]  sel_shift;
  logic [12:0] sel_avg;
  logic [24:0] sel_units;
  logic        sel_fast;
  logic [39:0] period_cyc;         // one output period in cycles
  logic [39:0] first_cyc;          // delay to the first sample
  logic        pulse_act;          // interrupt pulse running

  // ---------------------------------------------------------------
  // field decoders, one per state
  // ---------------------------------------------------------------
  srds_rate_decode u_wake_average_count (
    .code_i       (rate_cfg_r[`SRDS_WAKE_CODE_MSB:`SRDS_WAKE_CODE_LSB]),   // RULE1 RULE7
    .power_i      (wake_power_select_r),
    .idle_i       (wake_idle_r),
    .shift_o      (wake_shift),
    .avg_count_o  (wake_avg),
    .units_o      (wake_units),
    .fast_start_o (wake_fast)
  );

  srds_rate_decode u_sleep_average_count (
    .code_i       (rate_cfg_r[`SRDS_SLEEP_CODE_MSB:`SRDS_SLEEP_CODE_LSB]), // RULE1 RULE8
    .power_i      (sleep_power_select_r),
    .idle_i       (sleep_idle_r),
    .shift_o      (sleep_shift),
    .avg_count_o  (sleep_avg),
    .units_o      (sleep_units),
    .fast_start_o (sleep_fast)
  );

  // ---------------------------------------------------------------
  // field selection and period arithmetic
  // ---------------------------------------------------------------
  // the field in use follows the state applied by the sequencer,
  // so a change of state only takes hold after the gap
  always_comb
  begin
    tgt_sleep = (state_r == SRDS_ST_ACQ) ? sleep_applied_r : sleep_state_i;
    if (tgt_sleep)
    begin
      sel_shift = sleep_shift;                                               // RULE19 RULE11
      sel_avg   = sleep_avg;
      sel_units = sleep_units;
      sel_fast  = sleep_fast;
    end
    else
    begin
      sel_shift = wake_shift;                                                // RULE19 RULE11
      sel_avg   = wake_avg;
      sel_units = wake_units;
      sel_fast  = wake_fast;
    end
    period_cyc = 40'(sel_units) * 40'(UNIT_CYC);                             // RULE6 RULE10
    // start-up: base plus one step per extra averaged sample
    if (sel_fast)
      first_cyc = 40'(FIRST_BASE) + 40'(sel_avg - 13'h0001) * 40'(FIRST_STEP); // RULE9
    else
      first_cyc = period_cyc;                                                // RULE10
  end

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // a request is taken while waitrequest is high and answered the next
  // cycle; nothing is answered until the strap value has been loaded
  assign req               = (avs_read_i | avs_write_i) & ~ack_r & boot_done_r;
  assign wr_take           = avs_write_i & ack_r;
  assign idx               = {2'b00, avs_address_i[7:2]};
  assign avs_waitrequest_o = ~ack_r;
  assign avs_readdata_o    = rdata_r;

  // answer flag, one cycle per request
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  // read mux; unmapped indices read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `SRDS_IDX_RATE_CFG:
        rd_mux[7:0] = rate_cfg_r;
      `SRDS_IDX_CTRL:
      begin
        rd_mux[`SRDS_CTRL_RUN_BIT]                                   = run_en_r;
        rd_mux[`SRDS_CTRL_PIN2_BIT]                                  = pin2_func_r;
        rd_mux[`SRDS_CTRL_RDY_EN_BIT]                                = rdy_irq_en_r;
        rd_mux[`SRDS_CTRL_WAKE_POWER_SELECT_LSB+1:`SRDS_CTRL_WAKE_POWER_SELECT_LSB]      = wake_power_select_r;
        rd_mux[`SRDS_CTRL_SLEEP_POWER_SELECT_LSB+1:`SRDS_CTRL_SLEEP_POWER_SELECT_LSB]    = sleep_power_select_r;
      end
      `SRDS_IDX_WAKE_IDLE:
        rd_mux[11:0] = wake_idle_r;
      `SRDS_IDX_SLEEP_IDLE:
        rd_mux[11:0] = sleep_idle_r;
      `SRDS_IDX_STATUS:
      begin
        rd_mux[`SRDS_STAT_STANDBY_BIT]                   = (state_r == SRDS_ST_STANDBY);
        rd_mux[`SRDS_STAT_ACQ_BIT]                       = (state_r == SRDS_ST_ACQ);
        rd_mux[`SRDS_STAT_GAP_BIT]                       = (state_r == SRDS_ST_GAP);
        rd_mux[`SRDS_STAT_SLEEP_BIT]                     = sleep_applied_r;
        rd_mux[`SRDS_STAT_SHIFT_LSB+3:`SRDS_STAT_SHIFT_LSB] = sel_shift;
        rd_mux[`SRDS_STAT_AVG_LSB+12:`SRDS_STAT_AVG_LSB] = avg_r;
      end
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured when the request is taken, standing at the answer
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_r <= 32'h0000_0000;
    else if (req & avs_read_i)
      rdata_r <= rd_mux;
  end

  // ---------------------------------------------------------------
  // rate config register
  // ---------------------------------------------------------------
  // async reset clears it; the strap is caught on the first edge after
  // release, so the reset value never depends on a port under reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      boot_done_r <= 1'b0;
    else
      boot_done_r <= 1'b1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rate_cfg_r <= `SRDS_RATE_RST_GND;
    else if (!boot_done_r)
      rate_cfg_r <= boot_mode_pin_i ? `SRDS_RATE_RST_VDD : `SRDS_RATE_RST_GND; // RULE2
    // writes outside standby are dropped so a running period is never torn
    else if (wr_take && idx == `SRDS_IDX_RATE_CFG && avs_byteenable_i[0]
             && !run_en_r && !pin2_func_r)                                   // RULE13
      rate_cfg_r <= avs_writedata_i[7:0];                                    // RULE1
  end

  // ---------------------------------------------------------------
  // control and idle registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run_en_r     <= 1'b0;
      pin2_func_r  <= 1'b0;
      rdy_irq_en_r <= 1'b0;
      wake_power_select_r    <= 2'b00;
      sleep_power_select_r   <= 2'b00;
    end
    else if (wr_take && idx == `SRDS_IDX_CTRL && avs_byteenable_i[0])
    begin
      run_en_r     <= avs_writedata_i[`SRDS_CTRL_RUN_BIT];
      pin2_func_r  <= avs_writedata_i[`SRDS_CTRL_PIN2_BIT];
      rdy_irq_en_r <= avs_writedata_i[`SRDS_CTRL_RDY_EN_BIT];
      wake_power_select_r    <= avs_writedata_i[`SRDS_CTRL_WAKE_POWER_SELECT_LSB+1:`SRDS_CTRL_WAKE_POWER_SELECT_LSB];    // RULE17
      sleep_power_select_r   <= avs_writedata_i[`SRDS_CTRL_SLEEP_POWER_SELECT_LSB+1:`SRDS_CTRL_SLEEP_POWER_SELECT_LSB];  // RULE17
    end
  end

  // idle times, byte lanes 0 and 1
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wake_idle_r  <= `SRDS_IDLE_RST;
      sleep_idle_r <= `SRDS_IDLE_RST;
    end
    else if (wr_take)
    begin
      if (idx == `SRDS_IDX_WAKE_IDLE)
      begin
        if (avs_byteenable_i[0])
          wake_idle_r[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1])
          wake_idle_r[11:8] <= avs_writedata_i[11:8];
      end
      if (idx == `SRDS_IDX_SLEEP_IDLE)
      begin
        if (avs_byteenable_i[0])
          sleep_idle_r[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1])
          sleep_idle_r[11:8] <= avs_writedata_i[11:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  // one down counter times start-up, periods and the gap; a sample is
  // signalled on the cycle the counter runs out
  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    sample_nxt = 1'b0;
    case (state_r)
      SRDS_ST_STANDBY:
      begin
        if (run_en_r)
        begin
          state_nxt = SRDS_ST_ACQ;
          cnt_nxt   = first_cyc;                                             // RULE9 RULE10
        end
      end
      SRDS_ST_ACQ:
      begin
        if (!run_en_r)
          state_nxt = SRDS_ST_STANDBY;
        else if (sleep_state_i != sleep_applied_r)
        begin
          state_nxt = SRDS_ST_GAP;                                           // RULE12
          cnt_nxt   = 40'(GAP_CYC);
        end
        else if (cnt_r <= 40'h00_0000_0001)
        begin
          sample_nxt = 1'b1;
          cnt_nxt    = period_cyc;                                           // RULE10
        end
        else
          cnt_nxt = cnt_r - 40'h00_0000_0001;
      end
      SRDS_ST_GAP:
      begin
        if (!run_en_r)
          state_nxt = SRDS_ST_STANDBY;
        else if (cnt_r <= 40'h00_0000_0001)
        begin
          // new state's field and idle time take over after the gap
          state_nxt = SRDS_ST_ACQ;                                           // RULE12 RULE19
          cnt_nxt   = first_cyc;
        end
        else
          cnt_nxt = cnt_r - 40'h00_0000_0001;
      end
      default:
      begin
        state_nxt = SRDS_ST_STANDBY;
        cnt_nxt   = 40'h00_0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r  <= SRDS_ST_STANDBY;
      cnt_r    <= 40'h00_0000_0000;
      sample_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      sample_r <= sample_nxt;
    end
  end

  // applied state and average count latch on entry to acquisition
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sleep_applied_r <= 1'b0;
      avg_r           <= 13'h0001;
    end
    else if (state_r != SRDS_ST_ACQ && state_nxt == SRDS_ST_ACQ)
    begin
      sleep_applied_r <= sleep_state_i;                                      // RULE19 RULE11
      avg_r           <= sel_avg;
    end
  end

  assign sample_ready_o = sample_r;
  assign avg_count_o    = avg_r;

  // ---------------------------------------------------------------
  // motion-detect interrupt pulse
  // ---------------------------------------------------------------
  // with the strap high and rdy_irq_en_r set each sample pulls the line low for a fixed time;
  // above about 200 Hz the pulses merge and the host sees a steady low
  srds_pulse_timer #(
    .LEN (PULSE_CYC)
  ) u_pulse (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .trigger_i (sample_r & rdy_irq_en_r & boot_mode_pin_i),                  // RULE15
    .active_o  (pulse_act)
  );

  // line idles high, also through reset
  assign first_irq_line_n_o = ~pulse_act;                                    // RULE15

endmodule

//--- dv/srds_rate_select_sva.sv
// concurrent checks on the ports of the rate select block
`timescale 1ns/1ns
module srds_rate_select_sva (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  // register bus
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  // pins and sample timing
  input wire logic        boot_mode_pin_i,
  input wire logic        sleep_state_i,
  input wire logic        sample_ready_o,
  input wire logic [12:0] avg_count_o,
  input wire logic        first_irq_line_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // shortest period is one base unit, so seven quiet cycles must follow any sample
  sequence s_quiet;
    !sample_ready_o [*7];
  endsequence
  chk_sample_spacing: assert property (sample_ready_o |=> s_quiet)
    else $error("sample pulses closer than one base unit");
  chk_gap_quiet: assert property ($changed(sleep_state_i) |-> ##2 s_quiet)
    else $error("sample inside the wake sleep gap");
  chk_avg_legal: assert property ($onehot(avg_count_o) && avg_count_o <= 13'h1000)
    else $error("average count not a power of two up to 4096");
  chk_irq_strap: assert property (!boot_mode_pin_i |-> first_irq_line_n_o)
    else $error("interrupt line low with strap at ground");
  chk_irq_width: assert property ($fell(first_irq_line_n_o) |-> (!first_irq_line_n_o) [*4])
    else $error("interrupt pulse too short");
  chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
                                   |-> ##[1:3] !avs_waitrequest_o)
    else $error("register access not answered");
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_wait_idle: assert property (!avs_read_i && !avs_write_i |-> avs_waitrequest_o)
    else $error("answer without a request");
endmodule
bind srds_rate_select srds_rate_select_sva i_srds_rate_select_sva (.*);

//--- dv/srds_host_model.sv
// host processor model: avalon-mm master that configures the block
`timescale 1ns/1ns
module srds_host_model (
  // clock
  input  wire logic        clk_sys_i,
  // answer from the slave
  input  wire logic        avs_waitrequest_o,
  input  wire logic [31:0] avs_readdata_o,
  // request to the slave
  output logic      [7:0]  avs_address_i,
  output logic             avs_read_i,
  output logic             avs_write_i,
  output logic      [31:0] avs_writedata_i,
  output logic      [3:0]  avs_byteenable_i,
  output logic             hung_o
);
  initial
  begin
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, hung_o} = '0;
    avs_byteenable_i = 4'hF;
  end
  // one transfer, held until the rising edge at which waitrequest is seen low; read before that edge updates it
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 200);
    q = avs_readdata_o;
    hung_o = hung_o | (n >= 200);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
endmodule

//--- dv/test_srds_rate_select.sv
// self-checking bench for the rate select block
`timescale 1ns/1ns
module test_srds_rate_select;
  logic        clk_sys_i, rst_n_i, boot_mode_pin_i, sleep_state_i, hung_o;
  logic [7:0]  avs_address_i;
  logic        avs_read_i, avs_write_i, avs_waitrequest_o, sample_ready_o, first_irq_line_n_o;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic [12:0] avg_count_o;
  int          num_errors, checks, n;
  // counts shortened so the run stays small
  srds_rate_select #(.UNIT_CYC(8), .FIRST_BASE(12), .FIRST_STEP(7), .GAP_CYC(10), .PULSE_CYC(5))
    i_srds_rate_select (.*);
  srds_host_model i_srds_host_model (.*);
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_srds_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_srds_host_model.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  // rate codes go in only while stopped, then run is set
  task automatic run(input logic [7:0] c, input logic [7:0] r, input logic [11:0] wi, input logic [11:0] si);
    wr(8'h80, {24'h00_0000, c & 8'hFE});
    wr(8'h5C, {24'h00_0000, r});
    wr(8'h84, {20'h0_0000, wi});
    wr(8'h88, {20'h0_0000, si});
    wr(8'h80, {24'h00_0000, c});
  endtask
  // cycles up to the next sample pulse, sampled mid-cycle
  task automatic meas(output int k);
    k = 0;
    do
    begin
      @(negedge clk_sys_i);
      k++;
    end
    while (sample_ready_o !== 1'b1 && k < 4000);
    if (k >= 4000)
    begin
      num_errors++;
      print_verdict;
    end
  endtask
  always @(posedge hung_o)
  begin
    num_errors++;
    print_verdict;
  end
  initial
  begin
    {rst_n_i, boot_mode_pin_i, sleep_state_i, num_errors, checks} = '0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    chk_rd(8'h5C, 32'h0000_0000);
    wr(8'h5C, 32'h0000_00A5);
    chk_rd(8'h5C, 32'h0000_00A5);
    chk_rd(8'hFC, 32'h0000_0000);
    wr(8'h80, 32'h0000_0002);
    wr(8'h5C, 32'h0000_0011);
    chk_rd(8'h5C, 32'h0000_00A5);
    $display("test 1 registers done");
    for (int pm = 0; pm < 4; pm++)
    begin
      run({pm[1:0], pm[1:0], 4'h1}, 8'h20, 12'h001, 12'h001);
      meas(n);
      meas(n);
      chk(32'(n), (pm > 1) ? 64 : 32);
      chk({19'h0_0000, avg_count_o}, (pm > 0) ? 4 : 1);
    end
    wr(8'h5C, 32'h0000_0000);
    chk_rd(8'h5C, 32'h0000_0020);
    run(8'h11, 8'hD0, 12'h000, 12'h000);
    repeat (4) @(posedge clk_sys_i);
    chk({19'h0_0000, avg_count_o}, 32'h0000_1000);
    $display("test 2 power settings done");
    run(8'hA1, 8'h62, 12'h000, 12'h001);
    meas(n);
    chk(32'(n >= 451 && n <= 458), 32'h0000_0001);
    meas(n);
    chk(32'(n), 512);
    chk({19'h0_0000, avg_count_o}, 32'h0000_0040);
    @(posedge clk_sys_i);
    sleep_state_i <= 1'b1;
    meas(n);
    chk(32'(n >= 11 && n <= 80), 32'h0000_0001);
    meas(n);
    chk(32'(n), 64);
    chk({19'h0_0000, avg_count_o}, 32'h0000_0004);
    $display("test 3 tunable and sleep done");
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    boot_mode_pin_i <= 1'b1;
    sleep_state_i <= 1'b0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    chk_rd(8'h5C, 32'h0000_00C0);
    run(8'h05, 8'h50, 12'h000, 12'h000);
    meas(n);
    meas(n);
    n = 0;
    repeat (200)
    begin
      n += int'(first_irq_line_n_o === 1'b0);
      @(negedge clk_sys_i);
    end
    chk(32'(n), 5);
    $display("test 4 strap high done");
    print_verdict;
  end
endmodule
